// ===== design/pfs_sequencer.sv
// fault and protection sequencer of a boost power-factor controller
`timescale 1ns/10ps
module pfs_sequencer #(
  parameter int unsigned LONG_FAULT_CYCLES = pfs_pkg::LONG_FAULT_CYC,
  parameter int unsigned SUPPLY_FILT_CYCLES = pfs_pkg::SUPPLY_FILT_CYC,
  parameter int unsigned DCH_MIN_CYCLES = pfs_pkg::DCH_MIN_CYC,
  parameter int unsigned DCH_MID_CYCLES = pfs_pkg::DCH_MID_CYC,
  parameter int unsigned DCH_TOP_CYCLES = pfs_pkg::DCH_TOP_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // supply comparators
  input wire logic supply_above_start,
  input wire logic supply_below_stop,
  // current sense comparators on the drain current sense pin
  input wire logic peak_limit_cmp,
  input wire logic gross_current_cmp,
  // overvoltage comparators
  input wire logic output_overvolt_cmp,
  input wire logic drain_overvolt_cmp,
  // output window comparators around the regulation reference
  input wire logic output_above_window,
  input wire logic output_below_window,
  // cycle timing from the modulator
  input wire logic on_time_done,
  input wire logic zero_current,
  input wire logic burst_demand_on,
  input wire logic valley_ready,
  // gate and analog controls
  output logic gate_drive,
  output logic [2:0] soft_level,
  output logic comp_discharge_switch,
  output logic [2:0] ea_gain,
  // status
  output logic long_fault,
  output logic drain_overvolt_fault,
  output logic [1:0] dch_step,
  output logic switching
);
  localparam int TW = 26;

  pfs_pkg::pfs_state_t state_q, state_d;
  logic gate_q;
  logic [2:0] soft_q;
  logic [1:0] step_q;
  logic [15:0] on_cnt_q;
  logic [6:0] ov2_cnt_q;
  logic [6:0] ovf_cnt_q;
  logic ovf_arm_q, ov2_prev_q;
  logic cut_q, ov2_trip_q, short_q;
  logic waiting_q;
  logic disch_q, lf_q, d2f_q, sw_q;
  logic gross_trip_q;
  logic [2:0] gain_q;
  logic [TW-1:0] uv_cnt_q;

  // cycle decoding
  wire in_run = (state_q == pfs_pkg::PFS_RUN) || (state_q == pfs_pkg::PFS_SOFT_OFF);
  wire leb1_over = on_cnt_q >= 16'(pfs_pkg::LEB1_CYC);
  wire leb2_over = on_cnt_q >= 16'(pfs_pkg::LEB2_CYC);
  wire peak_limit_cmp_cut = gate_q && leb1_over && peak_limit_cmp;
  wire gross_current_cmp_cut = gate_q && leb2_over && gross_current_cmp;
  wire ocp_cut = peak_limit_cmp_cut || gross_current_cmp_cut;
  wire gate_off = gate_q && (ocp_cut || on_time_done);
  wire dch_period = !gate_q && waiting_q;
  wire ov2_valid = dch_period && (ov2_cnt_q >= 7'(pfs_pkg::OV2_BLANK_CYC));
  wire ov2_seen = ov2_valid && drain_overvolt_cmp;
  wire ov2_fall = ov2_valid && ov2_prev_q && !drain_overvolt_cmp;
  wire gap_short = ovf_arm_q && (ovf_cnt_q < 7'(pfs_pkg::OV2_EN_CYC));

  // maximum diode interval selected by the step
  wire [TW-1:0] dch_max = (step_q == 2'h0) ? TW'(DCH_MIN_CYCLES) :
                          (step_q == 2'h1) ? TW'(DCH_MID_CYCLES) : TW'(DCH_TOP_CYCLES);
  wire dch_running;
  wire start_next = waiting_q && (zero_current || !dch_running) && valley_ready;
  wire cycle_end = waiting_q && start_next;

  // fault qualifiers
  wire lf_hit, d2_hit;
  wire uv_trip = supply_below_stop && (uv_cnt_q >= TW'(SUPPLY_FILT_CYCLES));
  wire halt_now = lf_hit || d2_hit || uv_trip;
  wire hold_running;
  wire read_running;

  pfs_run3 u_gross_run
  (
    .clk(clk),
    .rst_n(rst_n),
    .cycle_end(cycle_end),
    .qualify(cut_q && gross_trip_q),
    .clear(!in_run),
    .hit(lf_hit)
  );

  pfs_run3 u_drain_run
  (
    .clk(clk),
    .rst_n(rst_n),
    .cycle_end(cycle_end),
    .qualify(short_q || (zero_current && gap_short)),
    .clear(!in_run),
    .hit(d2_hit)
  );

  pfs_timer #(.W(TW)) u_dch_timer
  (
    .clk(clk),
    .rst_n(rst_n),
    .load(gate_off),
    .value(dch_max),
    .running(dch_running)
  );

  pfs_timer #(.W(TW)) u_hold_timer
  (
    .clk(clk),
    .rst_n(rst_n),
    .load(lf_hit || d2_hit),
    .value(TW'(LONG_FAULT_CYCLES)),
    .running(hold_running)
  );

  pfs_timer #(.W(TW)) u_read_timer
  (
    .clk(clk),
    .rst_n(rst_n),
    .load(state_q == pfs_pkg::PFS_STOP && state_d == pfs_pkg::PFS_DLY_READ),
    .value(TW'(pfs_pkg::DELAY_READ_CYC)),
    .running(read_running)
  );

  // state sequencing
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      pfs_pkg::PFS_DORMANT:
        if (supply_above_start)
          state_d = pfs_pkg::PFS_STOP;
      pfs_pkg::PFS_STOP:
        if (!hold_running)
          state_d = pfs_pkg::PFS_DLY_READ;
      pfs_pkg::PFS_DLY_READ:
        if (!read_running)
          state_d = pfs_pkg::PFS_BURST_OFF;
      pfs_pkg::PFS_BURST_OFF:
        if (burst_demand_on && !output_overvolt_cmp)
          state_d = pfs_pkg::PFS_RUN;
      pfs_pkg::PFS_RUN:
        if (output_overvolt_cmp || !burst_demand_on)
          state_d = pfs_pkg::PFS_SOFT_OFF;
      pfs_pkg::PFS_SOFT_OFF:
        if (cycle_end && soft_q == 3'h1)
          state_d = pfs_pkg::PFS_BURST_OFF;
      default:
        state_d = pfs_pkg::PFS_DORMANT;
    endcase
    if (halt_now && in_run)
      state_d = pfs_pkg::PFS_STOP;
    if (uv_trip)
      state_d = pfs_pkg::PFS_DORMANT;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_q <= pfs_pkg::PFS_DORMANT;
    else
      state_q <= state_d;
  end

  // supply drop filter runs only while awake
  always_ff @(posedge clk)
  begin
    if (!rst_n || !supply_below_stop || state_q == pfs_pkg::PFS_DORMANT)
      uv_cnt_q <= '0;
    else if (!uv_trip)
      uv_cnt_q <= uv_cnt_q + 1'b1;
  end

  // gate pulse and on-time counter
  always_ff @(posedge clk)
  begin
    if (!rst_n || !in_run || halt_now)
    begin
      gate_q <= 1'b0;
      waiting_q <= 1'b0;
      on_cnt_q <= '0;
    end
    else if (gate_q)
    begin
      gate_q <= !gate_off;
      waiting_q <= gate_off;
      on_cnt_q <= on_cnt_q + 16'h1;
    end
    else if (!waiting_q || start_next)
    begin
      gate_q <= !(state_q == pfs_pkg::PFS_SOFT_OFF && soft_q == 3'h1 && waiting_q);
      waiting_q <= 1'b0;
      on_cnt_q <= '0;
    end
  end

  // soft ramp: modulator scales the on-time by soft_level out of four
  always_ff @(posedge clk)
  begin
    if (!rst_n || !in_run)
      soft_q <= 3'h1;
    else if (cycle_end && state_q == pfs_pkg::PFS_RUN && soft_q < pfs_pkg::SOFT_STEPS)
      soft_q <= soft_q + 3'h1;
    else if (cycle_end && state_q == pfs_pkg::PFS_SOFT_OFF && soft_q > 3'h1)
      soft_q <= soft_q - 3'h1;
  end

  // per-cycle records, cleared when the next pulse begins
  always_ff @(posedge clk)
  begin
    if (!rst_n || !in_run || (!gate_q && !waiting_q) || cycle_end)
    begin
      cut_q <= 1'b0;
      gross_trip_q <= 1'b0;
      ov2_trip_q <= 1'b0;
      short_q <= 1'b0;
    end
    else
    begin
      if (gate_off)
      begin
        cut_q <= ocp_cut;
        gross_trip_q <= gross_current_cmp_cut;
      end
      if (ov2_seen)
        ov2_trip_q <= 1'b1;
      if (zero_current && gap_short)
        short_q <= 1'b1;
    end
  end

  // maximum diode interval step, saturating both ways
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      step_q <= 2'h0;
    else if (gate_off && ocp_cut && step_q != 2'h2)
      step_q <= step_q + 2'h1;
    else if (gate_off && !ocp_cut && step_q != 2'h0)
      step_q <= step_q - 2'h1;
  end

  // drain overvoltage blanking and gap timing
  always_ff @(posedge clk)
  begin
    if (!rst_n || gate_q || !in_run)
    begin
      ov2_cnt_q <= '0;
      ovf_cnt_q <= '0;
      ovf_arm_q <= 1'b0;
      ov2_prev_q <= 1'b0;
    end
    else
    begin
      if (ov2_cnt_q != 7'h7f)
        ov2_cnt_q <= ov2_cnt_q + 7'h1;
      ov2_prev_q <= ov2_valid && drain_overvolt_cmp;
      if (ov2_fall)
      begin
        ovf_arm_q <= 1'b1;
        ovf_cnt_q <= '0;
      end
      else if (ovf_arm_q && ovf_cnt_q != 7'h7f)
        ovf_cnt_q <= ovf_cnt_q + 7'h1;
    end
  end

  // analog controls and status, all registered
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      disch_q <= 1'b0;
      lf_q <= 1'b0;
      d2f_q <= 1'b0;
      gain_q <= pfs_pkg::GAIN_NOMINAL;
      sw_q <= 1'b0;
    end
    else
    begin
      // held through a tripping run, dropped at the first clean cycle end
      if (state_q == pfs_pkg::PFS_STOP)
        disch_q <= 1'b1;
      else if (ov2_seen)
        disch_q <= 1'b1;
      else if (cycle_end)
        disch_q <= ov2_trip_q;
      else if (!in_run)
        disch_q <= 1'b0;
      lf_q <= lf_hit || (lf_q && state_q == pfs_pkg::PFS_STOP);
      d2f_q <= d2_hit || (d2f_q && state_q == pfs_pkg::PFS_STOP);
      gain_q <= (output_above_window || output_below_window) ? pfs_pkg::GAIN_FAST :
                pfs_pkg::GAIN_NOMINAL;
      sw_q <= in_run;
    end
  end

  assign gate_drive = gate_q;
  assign soft_level = soft_q;
  assign comp_discharge_switch = disch_q;
  assign ea_gain = gain_q;
  assign long_fault = lf_q;
  assign drain_overvolt_fault = d2f_q;
  assign dch_step = step_q;
  assign switching = sw_q;
endmodule

// ===== design/pfs_pkg.sv
// package: constants and state encoding for the fault and protection sequencer
package pfs_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_NS = 20;
  // maximum diode-conduction interval steps, in microseconds
  localparam int unsigned DCH_MIN_US = 250;
  localparam int unsigned DCH_MID_US = 500;
  localparam int unsigned DCH_TOP_US = 1000;
  localparam int unsigned DCH_MIN_CYC = DCH_MIN_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DCH_MID_CYC = DCH_MID_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DCH_TOP_CYC = DCH_TOP_US * (CLK_HZ / 1_000_000);
  // timing defaults (plain values, no printed figures)
  localparam int unsigned LEB1_NS = 200;
  localparam int unsigned LEB2_NS = 100;
  localparam int unsigned OV2_BLANK_NS = 1000;
  localparam int unsigned OV2_EN_NS = 2000;
  localparam int unsigned LEB1_CYC = (LEB1_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned LEB2_CYC = (LEB2_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned OV2_BLANK_CYC = (OV2_BLANK_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned OV2_EN_CYC = OV2_EN_NS / CLK_NS;
  localparam int unsigned SUPPLY_FILT_US = 20;
  localparam int unsigned LONG_FAULT_MS = 1000;
  localparam int unsigned SUPPLY_FILT_CYC = SUPPLY_FILT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned LONG_FAULT_CYC = LONG_FAULT_MS * (CLK_HZ / 1000);
  localparam int unsigned DELAY_READ_CYC = 64;
  localparam logic [1:0] FAULT_RUN_LEN = 2'h3;
  localparam logic [2:0] SOFT_STEPS = 3'h4;
  localparam logic [2:0] GAIN_NOMINAL = 3'h1;
  localparam logic [2:0] GAIN_FAST = 3'h6;

  typedef enum logic [5:0] {
    PFS_DORMANT   = 6'h01,
    PFS_STOP      = 6'h02,
    PFS_DLY_READ  = 6'h04,
    PFS_BURST_OFF = 6'h08,
    PFS_RUN       = 6'h10,
    PFS_SOFT_OFF  = 6'h20
  } pfs_state_t;
endpackage

// ===== design/pfs_run3.sv
// three-in-a-row cycle qualifier used by both consecutive-cycle faults
`timescale 1ns/10ps
module pfs_run3
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // cycle summary
  input wire logic cycle_end,
  input wire logic qualify,
  input wire logic clear,
  // result
  output logic hit
);
  logic [1:0] cnt_q;
  wire last = (cnt_q == pfs_pkg::FAULT_RUN_LEN - 2'h1);
  always_ff @(posedge clk)
  begin
    if (!rst_n || clear)
      cnt_q <= 2'h0;
    else if (cycle_end)
      cnt_q <= (qualify && !last) ? cnt_q + 2'h1 : 2'h0;
  end
  assign hit = cycle_end && qualify && last;
endmodule

// ===== design/pfs_timer.sv
// loadable down-counter that flags expiry
`timescale 1ns/10ps
module pfs_timer #(
  parameter int W = 26
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic load,
  input wire logic [W-1:0] value,
  // status
  output logic running
);
  logic [W-1:0] cnt_q;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else if (load)
      cnt_q <= value;
    else if (cnt_q != '0)
      cnt_q <= cnt_q - 1'b1;
  end
  assign running = (cnt_q != '0);
endmodule

// ===== sim/pfs_monitor.sv
// checker: timing relations at the sequencer ports
`timescale 1ns/10ps
module pfs_monitor #(
  parameter int unsigned SUPPLY_FILT_CYCLES = 10
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // sequencer inputs
  input wire logic supply_below_stop,
  input wire logic peak_limit_cmp,
  input wire logic gross_current_cmp,
  input wire logic output_overvolt_cmp,
  input wire logic drain_overvolt_cmp,
  input wire logic output_above_window,
  input wire logic output_below_window,
  input wire logic on_time_done,
  // sequencer outputs
  input wire logic gate_drive,
  input wire logic [2:0] soft_level,
  input wire logic comp_discharge_switch,
  input wire logic [2:0] ea_gain,
  input wire logic long_fault,
  input wire logic drain_overvolt_fault,
  input wire logic switching
);
  logic [7:0] on_q;
  logic [7:0] off_q;
  logic [7:0] low_q;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // off_q and low_q saturate so long idle spans cannot wrap into a window; on_q wraps
  always_ff @(posedge clk)
  begin
    on_q <= (!rst_n || !gate_drive) ? 8'h00 : on_q + 8'h01;
    off_q <= (!rst_n || gate_drive) ? 8'h00 : off_q + {7'h00, off_q != 8'hff};
    low_q <= (!rst_n || !supply_below_stop) ? 8'h00 : low_q + {7'h00, low_q != 8'hff};
  end
  a_gain_fast: assert property ((output_above_window || output_below_window)[*2]
    |-> ea_gain == pfs_pkg::GAIN_FAST) else $error("gain not fast");
  a_gain_nominal: assert property ((!(output_above_window || output_below_window))[*2]
    |-> ea_gain == pfs_pkg::GAIN_NOMINAL) else $error("gain not nominal");
  a_peak_end: assert property (gate_drive && on_q >= 8'h0a && peak_limit_cmp
    |=> !gate_drive) else $error("peak limit did not end pulse");
  a_peak_blank: assert property (gate_drive && on_q <= 8'h09 && peak_limit_cmp
    && !gross_current_cmp && !on_time_done |=> gate_drive) else $error("peak not blanked");
  a_gross_end: assert property (gate_drive && on_q >= 8'h05 && gross_current_cmp
    |=> !gate_drive) else $error("gross current did not end pulse");
  a_supply_drop: assert property (low_q > SUPPLY_FILT_CYCLES + 3
    |-> !gate_drive && !switching) else $error("switching after supply drop");
  a_fault_halt: assert property (long_fault || drain_overvolt_fault
    |-> !gate_drive) else $error("gate during fault");
  a_drain_trip: assert property (switching && !gate_drive && off_q >= 8'h37
    && off_q <= 8'h46 && drain_overvolt_cmp |=> comp_discharge_switch)
    else $error("discharge not on after trip");
  a_ov_hold: assert property (!switching && output_overvolt_cmp
    |=> !gate_drive) else $error("gate during overvoltage");
  a_soft_range: assert property (soft_level != 3'h0
    && soft_level <= pfs_pkg::SOFT_STEPS) else $error("soft step out of range");
endmodule

bind pfs_sequencer pfs_monitor #(.SUPPLY_FILT_CYCLES(SUPPLY_FILT_CYCLES)) u_mon (
  .clk(clk), .rst_n(rst_n), .supply_below_stop(supply_below_stop),
  .peak_limit_cmp(peak_limit_cmp), .gross_current_cmp(gross_current_cmp),
  .output_overvolt_cmp(output_overvolt_cmp), .drain_overvolt_cmp(drain_overvolt_cmp),
  .output_above_window(output_above_window), .output_below_window(output_below_window),
  .on_time_done(on_time_done), .gate_drive(gate_drive), .soft_level(soft_level),
  .comp_discharge_switch(comp_discharge_switch), .ea_gain(ea_gain),
  .long_fault(long_fault), .drain_overvolt_fault(drain_overvolt_fault),
  .switching(switching));

// ===== sim/pfs_switch_model.sv
// boost switch and sense model: on-time end and zero-current return
`timescale 1ns/10ps
module pfs_switch_model #(
  parameter int ON_CYC = 30,
  parameter int ZC_CYC = 90
)
(
  // clock
  input wire logic clk,
  // gate from the sequencer
  input wire logic gate_drive,
  // modulator and sense returns
  output logic on_time_done,
  output logic zero_current
);
  int on_n = 0;
  int off_n = 0;
  always @(posedge clk)
  begin
    on_n <= gate_drive ? on_n + 1 : 0;
    off_n <= gate_drive ? 0 : off_n + 1;
  end
  // inductor empties well before the shortest diode limit, so cycles restart on it
  assign on_time_done = gate_drive && on_n >= ON_CYC;
  assign zero_current = !gate_drive && off_n == ZC_CYC;
endmodule

// ===== sim/pfs_sequencer_test.sv
// self-checking bench for the fault and protection sequencer
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
  begin n_checks++; if ((got) !== (ex)) begin errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module pfs_sequencer_test;
  logic clk = 1'b0;
  logic rst_n, supply_above_start, supply_below_stop, peak_limit_cmp, gross_current_cmp;
  logic output_overvolt_cmp, drain_overvolt_cmp, output_above_window, output_below_window;
  logic burst_demand_on, on_time_done, zero_current, gate_drive, comp_discharge_switch;
  logic long_fault, drain_overvolt_fault, switching, valley_ready;
  logic [2:0] soft_level, ea_gain;
  logic [1:0] dch_step;
  int errors = 0;
  int n_checks = 0;
  localparam int DCH_MIN = 150;
  always #10 clk = ~clk;
  pfs_sequencer #(.LONG_FAULT_CYCLES(200), .SUPPLY_FILT_CYCLES(10), .DCH_MIN_CYCLES(DCH_MIN),
    .DCH_MID_CYCLES(300), .DCH_TOP_CYCLES(600)) u_dut (.clk(clk), .rst_n(rst_n),
    .supply_above_start(supply_above_start), .supply_below_stop(supply_below_stop),
    .peak_limit_cmp(peak_limit_cmp), .gross_current_cmp(gross_current_cmp),
    .output_overvolt_cmp(output_overvolt_cmp), .drain_overvolt_cmp(drain_overvolt_cmp),
    .output_above_window(output_above_window), .output_below_window(output_below_window),
    .on_time_done(on_time_done), .zero_current(zero_current),
    .burst_demand_on(burst_demand_on), .valley_ready(valley_ready), .gate_drive(gate_drive),
    .soft_level(soft_level), .comp_discharge_switch(comp_discharge_switch),
    .ea_gain(ea_gain), .long_fault(long_fault), .drain_overvolt_fault(drain_overvolt_fault),
    .dch_step(dch_step), .switching(switching));
  pfs_switch_model u_sw (.clk(clk), .gate_drive(gate_drive), .on_time_done(on_time_done),
    .zero_current(zero_current));

  task automatic complete_run;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // a hung gate counts as a mismatch and ends the run
  task automatic wait_gate(input logic lvl, input int lim, output int n);
    n = 0;
    while (gate_drive !== lvl && n < lim)
    begin
      step(1);
      n++;
    end
    if (n >= lim)
    begin
      errors++;
      complete_run();
    end
  endtask

  task automatic s_wake;
    int n;
    step(100);
    `CHK("dormant gate", 1'b0, gate_drive)
    supply_above_start = 1'b1;
    step(2);
    `CHK("stop discharge", 1'b1, comp_discharge_switch)
    wait_gate(1'b1, 600, n);
    `CHK("read delay", 1'b1, n >= 64)
  endtask

  task automatic s_gain;
    for (int i = 0; i < 3; i++)
    begin
      {output_above_window, output_below_window} = 2'h2 >> i;
      step(3);
      `CHK("gain", (i < 2) ? pfs_pkg::GAIN_FAST : pfs_pkg::GAIN_NOMINAL, ea_gain)
    end
  endtask

  task automatic s_peak;
    int n;
    logic [1:0] dch_exp [5] = '{2'h1, 2'h2, 2'h2, 2'h1, 2'h0};
    // start on a fresh pulse, not one already past its blanking
    wait_gate(1'b0, 40, n);
    for (int i = 0; i < 6; i++)
    begin
      wait_gate(1'b1, 400, n);
      if (i > 0) `CHK("dch step", dch_exp[i-1], dch_step)
      peak_limit_cmp = (i < 3);
      wait_gate(1'b0, 40, n);
      peak_limit_cmp = 1'b0;
      if (i < 3) `CHK("peak end", 1'b1, n >= 8 && n < 20)
    end
  endtask

  // missed zero-current event: the next pulse waits out the diode limit
  task automatic s_valley;
    int n;
    wait_gate(1'b1, 400, n);
    wait_gate(1'b0, 40, n);
    valley_ready = 1'b0;
    step(100);
    valley_ready = 1'b1;
    wait_gate(1'b1, 200, n);
    `CHK("dch wait", DCH_MIN - 99, n)
  endtask

  task automatic s_drain;
    int n;
    wait_gate(1'b1, 400, n);
    drain_overvolt_cmp = 1'b1;
    wait_gate(1'b0, 40, n);
    step(20);
    drain_overvolt_cmp = 1'b0;
    step(2);
    `CHK("blanked trip", 1'b0, comp_discharge_switch)
    step(38);
    drain_overvolt_cmp = 1'b1;
    step(3);
    drain_overvolt_cmp = 1'b0;
    step(1);
    `CHK("trip discharge", 1'b1, comp_discharge_switch)
    wait_gate(1'b1, 400, n);
    `CHK("discharge held", 1'b1, comp_discharge_switch)
    wait_gate(1'b0, 40, n);
    wait_gate(1'b1, 400, n);
    step(2);
    `CHK("discharge released", 1'b0, comp_discharge_switch)
    // three late trips in a row, each close to the zero-current event
    for (int k = 0; k < 3; k++)
    begin
      wait_gate(1'b1, 400, n);
      wait_gate(1'b0, 40, n);
      step(60);
      drain_overvolt_cmp = 1'b1;
      step(3);
      drain_overvolt_cmp = 1'b0;
      if (k == 2) `CHK("no early fault", 1'b0, drain_overvolt_fault)
    end
    step(30);
    `CHK("drain fault", 1'b1, drain_overvolt_fault)
    `CHK("fault discharge", 1'b1, comp_discharge_switch)
  endtask

  task automatic s_ovp;
    int n;
    wait_gate(1'b1, 400, n);
    output_overvolt_cmp = 1'b1;
    n = 0;
    while (switching && n < 2000)
    begin
      step(1);
      n++;
    end
    `CHK("ov halt", 1'b1, n < 2000)
    if (n >= 2000)
      complete_run();
    repeat (200)
    begin
      step(1);
      `CHK("ov hold", 1'b0, gate_drive)
    end
    output_overvolt_cmp = 1'b0;
    for (int j = 1; j < 5; j++)
    begin
      wait_gate(1'b1, 1000, n);
      `CHK("soft step", 3'(j), soft_level)
      wait_gate(1'b0, 40, n);
    end
  endtask

  task automatic s_gross;
    int n;
    for (int i = 0; i < 6; i++)
    begin
      wait_gate(1'b1, 400, n);
      gross_current_cmp = (i != 2);
      wait_gate(1'b0, 40, n);
      gross_current_cmp = 1'b0;
      step(2);
      if (i != 2) `CHK("gross end", 1'b1, n < 9)
      if (i == 4) `CHK("run broken", 1'b0, long_fault)
    end
    // the third cut cycle only counts once its diode interval ends
    step(90);
    `CHK("long fault", 1'b1, long_fault)
    wait_gate(1'b1, 1000, n);
    `CHK("fault hold", 1'b1, n >= 200)
  endtask

  task automatic s_supply;
    int n;
    supply_below_stop = 1'b1;
    step(5);
    supply_below_stop = 1'b0;
    step(2);
    `CHK("short dip", 1'b1, switching)
    supply_above_start = 1'b0;
    supply_below_stop = 1'b1;
    step(20);
    `CHK("supply stop", 1'b0, switching)
    supply_below_stop = 1'b0;
    step(100);
    `CHK("stays dormant", 1'b0, gate_drive)
    supply_above_start = 1'b1;
    wait_gate(1'b1, 1000, n);
    `CHK("rewake", 1'b1, n >= 64)
  endtask

  initial
  begin
    {rst_n, supply_above_start, supply_below_stop, peak_limit_cmp, gross_current_cmp} = '0;
    {output_overvolt_cmp, drain_overvolt_cmp, output_above_window} = '0;
    output_below_window = 1'b0;
    burst_demand_on = 1'b1;
    valley_ready = 1'b1;
    step(3);
    rst_n = 1'b1;
    `CHK("reset gain", pfs_pkg::GAIN_NOMINAL, ea_gain)
    `CHK("reset soft", 3'h1, soft_level)
    s_wake();
    s_gain();
    s_peak();
    s_valley();
    s_drain();
    s_ovp();
    s_gross();
    s_supply();
    complete_run();
  end
endmodule
